// >>> core/fbdr_defines.svh
`ifndef FBDR_DEFINES_SVH
`define FBDR_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define FBDR_ADDR_CTRL       8'h00
`define FBDR_ADDR_RESOL      8'h04
`define FBDR_ADDR_OFFSET     8'h08
`define FBDR_ADDR_MOFFSET    8'h0C
`define FBDR_ADDR_STEPS      8'h10
`define FBDR_ADDR_RANGE      8'h14
`define FBDR_ADDR_HOURS      8'h18
`define FBDR_ADDR_FWVER      8'h1C
`define FBDR_ADDR_STATUS     8'h20
`define FBDR_ADDR_MASTER     8'h24

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define FBDR_CTRL_CLASS_LO   0
`define FBDR_CTRL_CLASS_HI   1
`define FBDR_CTRL_DIR_BIT    2
`define FBDR_CTRL_SCALE_BIT  3
`define FBDR_CTRL_RST        4'h0
`define FBDR_HOURS_RST       32'hFFFF_FFFF

// ****************************************************************
// Report layout
// ****************************************************************
`define FBDR_IDX_FIRST       6'h01
`define FBDR_IDX_LAST_C1     6'h10
`define FBDR_IDX_LAST_C2     6'h39
`define FBDR_LEN_C1          8'h0A
`define FBDR_LEN_C2          8'h33
`define FBDR_ENC_TYPE        8'h07
`define FBDR_REVS            16'h0001
`define FBDR_ALM_SUPP        16'h0001
`define FBDR_PROFILE_VER     16'h0110
`define FBDR_SERIAL_FILL     8'h2A
`define FBDR_ALARM_W         5

// ****************************************************************
// Status bit positions
// ****************************************************************
`define FBDR_S1_PRM_FAULT    6
`define FBDR_S1_UNSUPP       4
`define FBDR_S1_EXT_PEND     3
`define FBDR_S1_CFG_FAULT    2
`define FBDR_S1_NOT_READY    1
`define FBDR_S2_SYNC         5
`define FBDR_S2_FREEZE       4
`define FBDR_S2_WDOG         3
`define FBDR_S2_SLAVE        2
`define FBDR_S2_STAT_DIAG    1
`define FBDR_S2_PRM_REQ      0
`define FBDR_S3_OVERFLOW     7

`endif

// >>> core/fbdr_pkg.sv
package fbdr_pkg;
  typedef enum logic [1:0] {
    FBDR_CLASS1,
    FBDR_CLASS2,
    FBDR_VENDOR,
    FBDR_VENDOR_SPEED
  } fbdr_class_t;

  typedef enum logic {
    FBDR_IDLE,
    FBDR_SEND
  } fbdr_state_t;
endpackage

// >>> core/fbdr_report.sv
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "fbdr_defines.svh"

// Overview of operation
// R1: Parameter-rejected flag, status byte 1 bit 6, after a refused parameter telegram.
// R2: Status byte 1 bit 4 set when a requested function is unsupported.
// R3: Status byte 1 bit 3 high exactly while an extended report is pending.
// R4: Status byte 1 bit 2 set when configuration identifiers are rejected.
// R5: Status byte 1 bit 1 set while cyclic exchange is not yet possible.
// R6: Master sets status byte 1 bit 7 for another master's lock.
// R7: Master sets bit 5 on no response, bit 0 for absent slave.
// R8: Master sets status byte 2 bit 7 when slave leaves poll list.
// R9: Status byte 2 bit 5 set once a SYNC command is received.
// R10: Status byte 2 bit 4 set once a FREEZE command is received.
// R11: Status byte 2 bit 3 reports the response watchdog being active.
// R12: Status byte 2 bit 2 always one; bit 6 reserved.
// R13: Status byte 2 bit 0 set while re-parameterization is needed.
// R14: Status byte 3 bit 7 flags extended diagnosis overrun; rest reserved.
// R15: Byte 4 holds the address of the last accepted parameterizing master.
// R16: Bytes 5 and 6 carry the 16-bit identification code, high first.
// R17: Byte 7 carries the count of extended bytes.
// R18: Report length follows the selected class; vendor classes use class 2.
// R19: Class 1 ends at byte 16 with resolution and revolution count.
// R20: Class 2 adds bytes 17 to 57 up to the serial number.
// R21: Byte 8 bits 0 to 4 are the five alarms, active high.
// R22: Masters sharing the slave send identical configuration and parameters.
// R23: Length counts the length byte and all following extended bytes.
// R24: Internal error sets pending and static flags, withholds position data.
// R25: Bytes go out in ascending order, wide fields high byte first.
// R26: Reserved and unused status and alarm bits read as zero.
module fbdr_report #(
  parameter logic [15:0] IDENT_CODE = 16'h5A5A // Arbitrary value
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic prm_accept_i,
  input wire logic prm_reject_i,
  input wire logic [7:0] prm_master_addr_i,
  input wire logic cfg_accept_i,
  input wire logic cfg_reject_i,
  input wire logic unsupported_req_i,
  input wire logic not_ready_i,
  input wire logic reparam_needed_i,
  input wire logic sync_cmd_i,
  input wire logic freeze_cmd_i,
  input wire logic response_watchdog_active_i,
  input wire logic [4:0] alarm_i,
  input wire logic diag_req_i,
  output logic [7:0] diag_byte_o,
  output logic diag_valid_o,
  output logic diag_last_o,
  input wire logic diag_ready_i,
  output logic pos_valid_o
);
  import fbdr_pkg::*;

  // ****************************************************************
  // Register file
  // ****************************************************************
  fbdr_class_t class_q;
  logic dir_q, scale_q;
  logic [31:0] resol_q, offset_q, moffset_q, steps_q, range_q, hours_q;
  logic [15:0] fwver_q;
  logic [7:0] master_q;
  logic [7:0] st1, st2, st3, alarm_byte, opstat, len;
  logic [5:0] last_idx;
  logic wb_req, wb_wr, done;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      class_q <= FBDR_CLASS1;
      dir_q <= 1'b0;
      scale_q <= 1'b0;
      resol_q <= 32'h0000_0000;
      offset_q <= 32'h0000_0000;
      moffset_q <= 32'h0000_0000;
      steps_q <= 32'h0000_0000;
      range_q <= 32'h0000_0000;
      hours_q <= `FBDR_HOURS_RST;
      fwver_q <= 16'h0000;
    end else if (wb_wr) begin
      case (wb_adr_i[7:0])
        `FBDR_ADDR_CTRL: begin
          if (wb_sel_i[0]) begin
            class_q <= fbdr_class_t'(
              wb_dat_i[`FBDR_CTRL_CLASS_HI:`FBDR_CTRL_CLASS_LO]);
            dir_q <= wb_dat_i[`FBDR_CTRL_DIR_BIT];
            scale_q <= wb_dat_i[`FBDR_CTRL_SCALE_BIT];
          end
        end
        `FBDR_ADDR_RESOL: resol_q <= merge(resol_q, wb_dat_i, wb_sel_i);
        `FBDR_ADDR_OFFSET: offset_q <= merge(offset_q, wb_dat_i, wb_sel_i);
        `FBDR_ADDR_MOFFSET: begin
          moffset_q <= merge(moffset_q, wb_dat_i, wb_sel_i);
        end
        `FBDR_ADDR_STEPS: steps_q <= merge(steps_q, wb_dat_i, wb_sel_i);
        `FBDR_ADDR_RANGE: range_q <= merge(range_q, wb_dat_i, wb_sel_i);
        `FBDR_ADDR_HOURS: hours_q <= merge(hours_q, wb_dat_i, wb_sel_i);
        `FBDR_ADDR_FWVER: begin
          fwver_q <= 16'(merge({16'h0000, fwver_q}, wb_dat_i, wb_sel_i));
        end
        default: ;
      endcase
    end
  end

  // Unmapped addresses still ack and read zero so the master never hangs
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i[7:0])
        `FBDR_ADDR_CTRL: wb_dat_o <= {28'h000_0000, scale_q, dir_q, class_q};
        `FBDR_ADDR_RESOL: wb_dat_o <= resol_q;
        `FBDR_ADDR_OFFSET: wb_dat_o <= offset_q;
        `FBDR_ADDR_MOFFSET: wb_dat_o <= moffset_q;
        `FBDR_ADDR_STEPS: wb_dat_o <= steps_q;
        `FBDR_ADDR_RANGE: wb_dat_o <= range_q;
        `FBDR_ADDR_HOURS: wb_dat_o <= hours_q;
        `FBDR_ADDR_FWVER: wb_dat_o <= {16'h0000, fwver_q};
        `FBDR_ADDR_STATUS: wb_dat_o <= {alarm_byte, st3, st2, st1};
        `FBDR_ADDR_MASTER: wb_dat_o <= {24'h00_0000, master_q};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Station status flags
  // ****************************************************************
  logic prm_fault_q, cfg_fault_q, unsupp_q, sync_q, freeze_q;
  logic prm_req_q, wdog_q, not_ready_q, ext_new_q, ovf_q, err_q;
  logic [4:0] alarm_q;

  // Flags cleared by a sent report keep an event of the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prm_fault_q <= 1'b0;
      cfg_fault_q <= 1'b0;
      unsupp_q <= 1'b0;
      master_q <= 8'hFF;
    end else begin
      if (prm_reject_i) begin
        prm_fault_q <= 1'b1; // [R1]
      end else if (prm_accept_i) begin
        prm_fault_q <= 1'b0;
      end
      if (prm_accept_i && !prm_reject_i) begin
        master_q <= prm_master_addr_i; // [R15]
      end
      if (cfg_reject_i) begin
        cfg_fault_q <= 1'b1; // [R4]
      end else if (cfg_accept_i) begin
        cfg_fault_q <= 1'b0;
      end
      if (unsupported_req_i) begin
        unsupp_q <= 1'b1; // [R2]
      end else if (done) begin
        unsupp_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sync_q <= 1'b0;
      freeze_q <= 1'b0;
      prm_req_q <= 1'b1;
      wdog_q <= 1'b0;
      not_ready_q <= 1'b1;
    end else begin
      if (sync_cmd_i) begin
        sync_q <= 1'b1; // [R9]
      end else if (prm_accept_i) begin
        sync_q <= 1'b0;
      end
      if (freeze_cmd_i) begin
        freeze_q <= 1'b1; // [R10]
      end else if (prm_accept_i) begin
        freeze_q <= 1'b0;
      end
      if (reparam_needed_i) begin
        prm_req_q <= 1'b1; // [R13]
      end else if (prm_accept_i && !prm_reject_i) begin
        prm_req_q <= 1'b0;
      end
      wdog_q <= response_watchdog_active_i; // [R11]
      not_ready_q <= not_ready_i; // [R5]
    end
  end

  // Alarms are level inputs; the report stays pending while any is high
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      alarm_q <= 5'h00;
      err_q <= 1'b0;
      ext_new_q <= 1'b0;
      ovf_q <= 1'b0;
      pos_valid_o <= 1'b0;
    end else begin
      alarm_q <= alarm_i; // [R21]
      err_q <= |alarm_i; // [R24]
      pos_valid_o <= ~|alarm_i; // [R24]
      if (|(alarm_i & ~alarm_q) || prm_accept_i) begin
        ext_new_q <= 1'b1;
      end else if (done) begin
        ext_new_q <= 1'b0;
      end
      // A newly raised alarm while an event is still unread overruns the report
      if (ext_new_q && |(alarm_i & ~alarm_q)) begin
        ovf_q <= 1'b1; // [R14]
      end else if (done) begin
        ovf_q <= 1'b0;
      end
    end
  end

  always_comb begin
    st1 = 8'h00; // [R26]
    st1[`FBDR_S1_PRM_FAULT] = prm_fault_q;
    st1[`FBDR_S1_UNSUPP] = unsupp_q;
    st1[`FBDR_S1_EXT_PEND] = ext_new_q || err_q; // [R3] [R24]
    st1[`FBDR_S1_CFG_FAULT] = cfg_fault_q;
    st1[`FBDR_S1_NOT_READY] = not_ready_q;
    st2 = 8'h00; // [R26]
    st2[`FBDR_S2_SYNC] = sync_q;
    st2[`FBDR_S2_FREEZE] = freeze_q;
    st2[`FBDR_S2_WDOG] = wdog_q;
    st2[`FBDR_S2_SLAVE] = 1'b1; // [R12]
    st2[`FBDR_S2_STAT_DIAG] = err_q;
    st2[`FBDR_S2_PRM_REQ] = prm_req_q;
    st3 = 8'h00;
    st3[`FBDR_S3_OVERFLOW] = ovf_q; // [R14]
    alarm_byte = {3'b000, alarm_q}; // [R21] [R26]
    opstat = {class_q != FBDR_CLASS1 && class_q != FBDR_CLASS2, 3'b000,
              scale_q, 1'b1, class_q != FBDR_CLASS1, dir_q};
    if (class_q == FBDR_CLASS1) begin
      len = `FBDR_LEN_C1; // [R17] [R23]
      last_idx = `FBDR_IDX_LAST_C1; // [R18] [R19]
    end else begin
      len = `FBDR_LEN_C2; // [R17] [R23]
      last_idx = `FBDR_IDX_LAST_C2; // [R18] [R20]
    end
  end

  // ****************************************************************
  // Report serialiser
  // ****************************************************************
  function automatic logic [7:0] pick(input logic [31:0] w,
                                      input logic [1:0] k);
    return w[8*(3-k) +: 8]; // [R25]
  endfunction

  function automatic logic [7:0] get_byte(input logic [5:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      6'h01: b = st1;
      6'h02: b = st2;
      6'h03: b = st3;
      6'h04: b = master_q;
      6'h05: b = IDENT_CODE[15:8]; // [R16]
      6'h06: b = IDENT_CODE[7:0];
      6'h07: b = len;
      6'h08: b = alarm_byte;
      6'h09: b = opstat;
      6'h0A: b = `FBDR_ENC_TYPE;
      6'h0F: b = pick({16'h0000, `FBDR_REVS}, 2'd2);
      6'h10: b = pick({16'h0000, `FBDR_REVS}, 2'd3);
      6'h12: b = pick({16'h0000, `FBDR_ALM_SUPP}, 2'd2);
      6'h13: b = pick({16'h0000, `FBDR_ALM_SUPP}, 2'd3);
      6'h18: b = pick({16'h0000, `FBDR_PROFILE_VER}, 2'd2);
      6'h19: b = pick({16'h0000, `FBDR_PROFILE_VER}, 2'd3);
      6'h1A: b = fwver_q[15:8];
      6'h1B: b = fwver_q[7:0];
      default: begin
        if (idx >= 6'h0B && idx <= 6'h0E) begin
          b = pick(resol_q, 2'(idx - 6'h0B)); // [R19]
        end else if (idx >= 6'h1C && idx <= 6'h1F) begin
          b = pick(hours_q, 2'(idx - 6'h1C)); // [R20]
        end else if (idx >= 6'h20 && idx <= 6'h23) begin
          b = pick(offset_q, 2'(idx - 6'h20));
        end else if (idx >= 6'h24 && idx <= 6'h27) begin
          b = pick(moffset_q, 2'(idx - 6'h24));
        end else if (idx >= 6'h28 && idx <= 6'h2B) begin
          b = pick(steps_q, 2'(idx - 6'h28));
        end else if (idx >= 6'h2C && idx <= 6'h2F) begin
          b = pick(range_q, 2'(idx - 6'h2C));
        end else if (idx >= 6'h30 && idx <= 6'h39) begin
          b = `FBDR_SERIAL_FILL;
        end
      end
    endcase
    return b;
  endfunction

  fbdr_state_t state_q;
  logic [5:0] idx_q;

  assign done = state_q == FBDR_SEND && diag_ready_i && diag_last_o;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_q <= FBDR_IDLE;
      idx_q <= 6'h00;
      diag_byte_o <= 8'h00;
      diag_valid_o <= 1'b0;
      diag_last_o <= 1'b0;
    end else begin
      case (state_q)
        FBDR_IDLE: begin
          if (diag_req_i) begin
            state_q <= FBDR_SEND;
            idx_q <= `FBDR_IDX_FIRST;
            diag_byte_o <= get_byte(`FBDR_IDX_FIRST);
            diag_valid_o <= 1'b1;
            diag_last_o <= 1'b0;
          end
        end
        FBDR_SEND: begin
          if (diag_ready_i) begin
            if (diag_last_o) begin
              state_q <= FBDR_IDLE;
              diag_valid_o <= 1'b0;
              diag_last_o <= 1'b0;
            end else begin
              idx_q <= idx_q + 6'h01; // [R25]
              diag_byte_o <= get_byte(idx_q + 6'h01);
              diag_last_o <= (idx_q + 6'h01) == last_idx; // [R18]
            end
          end
        end
        default: state_q <= FBDR_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_prm_fault_set: assert property (@(posedge sys_clk_i) // [R1]
    disable iff (sys_rst_i) prm_reject_i |=> st1[`FBDR_S1_PRM_FAULT])
    else $error("parameter fault flag not set");
  a_unsupp_set: assert property (@(posedge sys_clk_i) // [R2]
    disable iff (sys_rst_i) unsupported_req_i |=> st1[`FBDR_S1_UNSUPP])
    else $error("unsupported flag not set");
  a_ext_pending: assert property (@(posedge sys_clk_i) // [R3]
    disable iff (sys_rst_i) |alarm_i |=> st1[`FBDR_S1_EXT_PEND])
    else $error("extended report not pending on alarm");
  a_sync_freeze: assert property (@(posedge sys_clk_i) // [R9]
    disable iff (sys_rst_i) sync_cmd_i || freeze_cmd_i |=>
      (st2[`FBDR_S2_SYNC] || !$past(sync_cmd_i)) &&
      (st2[`FBDR_S2_FREEZE] || !$past(freeze_cmd_i)))
    else $error("sync or freeze flag missing");
  a_wdog_follow: assert property (@(posedge sys_clk_i) // [R11]
    disable iff (sys_rst_i)
      st2[`FBDR_S2_WDOG] == $past(response_watchdog_active_i))
    else $error("watchdog bit mismatch");
  a_ident_hi: assert property (@(posedge sys_clk_i) // [R16]
    disable iff (sys_rst_i) diag_valid_o && idx_q == 6'h05 |->
      diag_byte_o == IDENT_CODE[15:8])
    else $error("identifier high byte wrong");
  a_len_byte: assert property (@(posedge sys_clk_i) // [R23]
    disable iff (sys_rst_i) diag_valid_o && idx_q == 6'h07 |->
      diag_byte_o == ((class_q == FBDR_CLASS1) ? `FBDR_LEN_C1 :
        `FBDR_LEN_C2))
    else $error("length byte wrong");
  a_pos_hold: assert property (@(posedge sys_clk_i) // [R24]
    disable iff (sys_rst_i) |alarm_i |=> !pos_valid_o ##0
      st2[`FBDR_S2_STAT_DIAG])
    else $error("position not withheld on error");
  a_byte_order: assert property (@(posedge sys_clk_i) // [R25]
    disable iff (sys_rst_i) diag_valid_o && diag_ready_i && !diag_last_o
      |=> idx_q == $past(idx_q) + 6'h01)
    else $error("bytes out of order");
  a_slave_bit: assert property (@(posedge sys_clk_i) // [R12]
    disable iff (sys_rst_i) diag_valid_o && idx_q == 6'h02 |->
      diag_byte_o[2] && !diag_byte_o[6] && !diag_byte_o[7])
    else $error("station status 2 fixed bits wrong");
endmodule
`default_nettype wire

// >>> testbench/fbdr_dp_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Polling master: one report per poll, drained with random stalls
// ****************************************
module fbdr_dp_master_model (
  input wire logic sys_clk_i,
  input wire logic poll_i,
  input wire logic diag_valid_i,
  input wire logic diag_last_i,
  output logic diag_req_o,
  output logic diag_ready_o,
  output logic done_o,
  output logic silent_o
);
  int idle;
  bit fin;

  // Single master: never reports a foreign lock never drops the
  // slave from its poll list sends one parameter set only
  initial begin
    diag_req_o = 1'b0;
    diag_ready_o = 1'b0;
    done_o = 1'b0;
    silent_o = 1'b0;
    forever begin
      @(posedge sys_clk_i);
      if (poll_i && !done_o) begin
        diag_req_o <= 1'b1;
        idle = 0;
        fin = 1'b0;
        while (!fin) begin
          @(posedge sys_clk_i);
          diag_req_o <= 1'b0;
          fin = diag_valid_i && diag_ready_o && diag_last_i;
          idle = diag_valid_i ? 0 : idle + 1;
          // A slave that stays quiet is flagged as not answering
          if (idle > 8) begin
            silent_o <= 1'b1;
            fin = 1'b1;
          end
          // Stalls keep each byte standing for a random number of cycles
          diag_ready_o <= !fin && ($urandom_range(2) != 0);
        end
        done_o <= 1'b1;
      end else if (!poll_i) begin
        done_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/fbdr_report_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbdr_defines.svh"

module fbdr_report_tb_top;
  import fbdr_pkg::*;
  localparam logic [15:0] IDENT = 16'h3C96; // Arbitrary value
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [3:0] sel = 4'h0;
  logic [31:0] adr = 32'h0000_0000, wdat = 32'h0000_0000, rdat;
  logic [7:0] ev = 8'h00, maddr = 8'h00, dbyte, ex;
  logic nrdy = 1'b1, wdog = 1'b0, req, ready, valid, last, posv;
  logic poll = 1'b0, done, silent, lastx;
  logic [4:0] alarm = 5'h00, alm = 5'h00;
  logic prm_f = 1'b0, unsup = 1'b0, ext_new = 1'b0, cfg_f = 1'b0;
  logic nrdy_m = 1'b1, syn = 1'b0, frz = 1'b0, wd_m = 1'b0;
  logic preq = 1'b1, ovf = 1'b0;
  logic [7:0] madr_m = 8'hFF;
  logic [31:0] rv [8];
  logic [31:0] rd_q [$];
  logic [7:0] rep_q [$];
  int n_mismatch = 0;
  int checks = 0;

  fbdr_report #(.IDENT_CODE(IDENT)) i_fbdr_report (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .prm_accept_i(ev[0]), .prm_reject_i(ev[1]),
    .prm_master_addr_i(maddr), .cfg_accept_i(ev[2]),
    .cfg_reject_i(ev[3]), .unsupported_req_i(ev[4]),
    .not_ready_i(nrdy), .reparam_needed_i(ev[7]), .sync_cmd_i(ev[5]),
    .freeze_cmd_i(ev[6]), .response_watchdog_active_i(wdog),
    .alarm_i(alarm), .diag_req_i(req), .diag_byte_o(dbyte),
    .diag_valid_o(valid), .diag_last_o(last), .diag_ready_i(ready),
    .pos_valid_o(posv));

  fbdr_dp_master_model i_fbdr_dp_master_model (
    .sys_clk_i(sys_clk_i), .poll_i(poll), .diag_valid_i(valid),
    .diag_last_i(last), .diag_req_o(req), .diag_ready_o(ready),
    .done_o(done), .silent_o(silent));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic final_report();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] status_exp();
    logic [7:0] s1, s2;
    s1 = {1'b0, prm_f, 1'b0, unsup, ext_new | (|alm), cfg_f, nrdy_m, 1'b0};
    s2 = {2'b00, syn, frz, wd_m, 1'b1, |alm, preq};
    return {3'b000, alm, ovf, 7'h00, s2, s1};
  endfunction

  // Classic cycle: hold everything until ack is seen at an edge
  task automatic wb(input logic [7:0] a, input logic [31:0] d,
                    input logic w);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= {24'h00_0000, a};
    wdat <= d;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) cmp(32'h0000_0000, 32'h0000_0001);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(a, 32'h0000_0000, 1'b0);
  endtask

  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge sys_clk_i);
    ev <= 8'h00;
    @(posedge sys_clk_i);
    case (k)
      0: begin
        {prm_f, syn, frz, preq, ext_new} = 5'b00001;
        madr_m = maddr;
      end
      1: prm_f = 1'b1;
      2: cfg_f = 1'b0;
      3: cfg_f = 1'b1;
      4: unsup = 1'b1;
      5: syn = 1'b1;
      6: frz = 1'b1;
      default: preq = 1'b1;
    endcase
  endtask

  task automatic set_alarm(input logic [4:0] a);
    alarm <= a;
    if ((a & ~alm) != 5'h00) begin
      ovf = ovf | ext_new;
      ext_new = 1'b1;
    end
    alm = a;
    repeat (3) @(posedge sys_clk_i);
    cmp({31'h0000_0000, posv}, {31'h0000_0000, a == 5'h00});
  endtask

  task automatic push4(input logic [31:0] v);
    for (int i = 3; i >= 0; i--) rep_q.push_back(v[8 * i +: 8]);
  endtask

  task automatic run_report();
    logic [31:0] st;
    logic [1:0] c;
    int n;
    st = status_exp();
    c = rv[0][1:0];
    push4({st[7:0], st[15:8], st[23:16], madr_m});
    push4({IDENT, (c == 2'b00) ? 8'h0A : 8'h33, st[31:24]});
    push4({c[1], 3'b000, rv[0][3], 1'b1, c != 2'b00, rv[0][2], 24'h07_0000});
    rep_q.delete(rep_q.size() - 1);
    rep_q.delete(rep_q.size() - 1);
    push4(rv[1]);
    push4({16'h0001, 16'h0000});
    rep_q.delete(rep_q.size() - 1);
    rep_q.delete(rep_q.size() - 1);
    if (c != 2'b00) begin
      push4({8'h00, 16'h0001, 8'h00});
      push4({24'h00_0000, 8'h01});
      push4({8'h10, rv[7][15:0], 8'h00});
      rep_q.delete(rep_q.size() - 1);
      for (int i = 6; i > 1; i--) push4(rv[i == 6 ? 6 : 7 - i]);
      repeat (10) rep_q.push_back(8'h2A);
    end
    poll <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (done !== 1'b1 && n < 400);
    poll <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    cmp(rep_q.size(), 32'h0000_0000);
    rep_q.delete();
    {unsup, ovf, ext_new} = 3'b000;
  endtask

  // ****************************************
  // Result monitor
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0) begin
      cmp(rdat, rd_q.pop_front());
    end
    if (valid === 1'b1 && ready === 1'b1) begin
      lastx = (rep_q.size() == 1);
      ex = (rep_q.size() > 0) ? rep_q.pop_front() : 8'hxx;
      cmp({23'h00_0000, last, dbyte}, {23'h00_0000, lastx, ex});
    end
  end

  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    final_report();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rv[0] = 32'h0000_0000;
    void'($urandom(32'h4653_2CF7));
    repeat (12) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(`FBDR_ADDR_STATUS, status_exp());
    rd(`FBDR_ADDR_HOURS, 32'hFFFF_FFFF);
    rd(`FBDR_ADDR_MASTER, 32'h0000_00FF);
    rd(`FBDR_ADDR_CTRL, 32'h0000_0000);
    wb(8'h40, 32'hFFFF_FFFF, 1'b1);
    rd(8'h40, 32'h0000_0000);
    for (int i = 1; i < 8; i++) begin
      rv[i] = $urandom();
      wb(8'(4 * i), rv[i], 1'b1);
    end
    rd(`FBDR_ADDR_RESOL, rv[1]);
    nrdy <= 1'b0;
    wdog <= 1'b1;
    maddr <= 8'($urandom_range(125, 1));
    {nrdy_m, wd_m} = 2'b01;
    for (int k = 1; k <= 8; k++) begin
      pulse(k % 8);
      rd(`FBDR_ADDR_STATUS, status_exp());
    end
    rd(`FBDR_ADDR_MASTER, {24'h00_0000, madr_m});
    for (int c = 0; c < 4; c++) begin
      rv[0] = {28'h000_0000, 2'($urandom()), 2'(c)};
      wb(`FBDR_ADDR_CTRL, rv[0], 1'b1);
      if (c == 1) pulse(0);
      set_alarm(c[0] ? (5'($urandom()) | 5'h01) : 5'h00);
      run_report();
    end
    cmp({31'h0000_0000, silent}, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire
